/* hw/colc_top.v */
// colc_top: two camera output lines (lines three and four) with pulse generator and
// software level control, behind an AXI4-Lite slave; inputs synchronous to mclk.
`timescale 1ns/1ps
`include "colc_defines.vh"

module colc_top #(
    parameter NOUT  = 2,
    parameter NIN   = 2
) (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire [NIN-1:0] line_in,
    output reg  [NOUT-1:0] line_out,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    localparam CW = `COLC_CNT_W;
    localparam [3:0] US_LAST = `COLC_US_CYCLES - 1;
    localparam [1:0] S_IDLE  = 2'h0;
    localparam [1:0] S_DELAY = 2'h1;
    localparam [1:0] S_PULSE = 2'h2;

    // control registers
    reg [2*NOUT-1:0] origin;
    reg [1:0]        activ;
    reg [CW-1:0]     delay_us;
    reg [CW-1:0]     width_us;
    reg [NOUT-1:0]   hold_latch;
    reg [NOUT-1:0]   level_set;
    reg [NOUT-1:0]   dir_out;
    reg [NOUT-1:0]   src_sel;
    reg [NOUT-1:0]   held_level;
    reg [NIN-1:0]    in_prev;

    // write channel capture
    reg [7:0]  wa;
    reg        wa_ok;
    reg [31:0] wd;
    reg [3:0]  ws;
    reg        wd_ok;
    wire       do_wr = wa_ok && wd_ok && !s_axi_bvalid;
    wire [NOUT-1:0] strobe = (do_wr && wa == `COLC_A_STROBE && ws[0]) ?
                             wd[NOUT-1:0] : {NOUT{1'b0}};

    function known_addr;
        input [7:0] a;
        begin
            known_addr = (a <= `COLC_A_SEL) && (a[1:0] == 2'h0);
        end
    endfunction

    always @(posedge mclk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `COLC_RESP_OKAY;
            wa_ok <= 1'b0;
            wd_ok <= 1'b0;
            wa    <= 8'h00;
            wd    <= 32'h00000000;
            ws    <= 4'h0;
            origin     <= {2*NOUT{1'b0}};
            activ      <= `COLC_ACT_RISE;
            delay_us   <= `COLC_DELAY_RST;
            width_us   <= `COLC_WIDTH_RST;
            hold_latch <= {NOUT{1'b0}};
            level_set  <= {NOUT{1'b0}};
            dir_out    <= {NOUT{1'b1}};
            src_sel    <= {NOUT{1'b0}};
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wa <= s_axi_awaddr;
                wa_ok <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd <= s_axi_wdata;
                ws <= s_axi_wstrb;
                wd_ok <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                wa_ok <= 1'b0;
                wd_ok <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known_addr(wa) && wa != `COLC_A_STATUS ?
                               `COLC_RESP_OKAY : `COLC_RESP_SLVERR;
                if (ws[0]) begin
                    case (wa)
                        `COLC_A_ORIGIN: origin <= wd[2*NOUT-1:0];
                        `COLC_A_ACTIV:  activ <= wd[1:0];
                        `COLC_A_HOLD:   hold_latch <= wd[NOUT-1:0];
                        `COLC_A_LEVEL:  level_set <= wd[NOUT-1:0];
                        `COLC_A_DIR:    dir_out <= wd[NOUT-1:0];
                        `COLC_A_SEL:    src_sel <= wd[NOUT-1:0];
                        default: ;
                    endcase
                end
                if (wa == `COLC_A_DELAY) begin
                    if (ws[0]) delay_us[7:0] <= wd[7:0];
                    if (ws[1]) delay_us[15:8] <= wd[15:8];
                    if (ws[2]) delay_us[23:16] <= wd[23:16];
                end
                if (wa == `COLC_A_WIDTH) begin
                    if (ws[0]) width_us[7:0] <= wd[7:0];
                    if (ws[1]) width_us[15:8] <= wd[15:8];
                    if (ws[2]) width_us[23:16] <= wd[23:16];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel: status sampled at the accept edge
    always @(posedge mclk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `COLC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= known_addr(s_axi_araddr) ? `COLC_RESP_OKAY : `COLC_RESP_SLVERR;
            case (s_axi_araddr)
                `COLC_A_ORIGIN: s_axi_rdata <= {{(32-2*NOUT){1'b0}}, origin};
                `COLC_A_ACTIV:  s_axi_rdata <= {30'h00000000, activ};
                `COLC_A_DELAY:  s_axi_rdata <= {8'h00, delay_us};
                `COLC_A_WIDTH:  s_axi_rdata <= {8'h00, width_us};
                `COLC_A_HOLD:   s_axi_rdata <= {{(32-NOUT){1'b0}}, hold_latch};
                `COLC_A_LEVEL:  s_axi_rdata <= {{(32-NOUT){1'b0}}, level_set};
                // line1, line2 inputs low bits, then output lines
                `COLC_A_STATUS: s_axi_rdata <= {{(32-NIN-NOUT){1'b0}}, line_out, line_in};
                `COLC_A_DIR:    s_axi_rdata <= {{(32-NOUT){1'b0}}, dir_out};
                `COLC_A_SEL:    s_axi_rdata <= {{(32-NOUT){1'b0}}, src_sel};
                default:        s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (!rst_b)
            in_prev <= {NIN{1'b0}};
        else
            in_prev <= line_in;
    end

    genvar g;
    generate
        for (g = 0; g < NOUT; g = g + 1) begin : gl
            reg  [1:0]    st;
            reg  [CW-1:0] cnt;
            // per line microsecond prescaler, restarted at each phase so
            // delay and width are whole microseconds, not tick-phase dependent
            reg  [3:0]    sub;
            wire          sub_wrap = (sub == US_LAST);
            wire [1:0]    org = origin[2*g+1:2*g];
            wire          src = line_in[src_sel[g]];
            wire          was = in_prev[src_sel[g]];
            wire          rise = src && !was;
            wire          fall = !src && was;
            wire          edge_hit = (activ == `COLC_ACT_RISE && rise) ||
                                     (activ == `COLC_ACT_FALL && fall) ||
                                     (activ == `COLC_ACT_BOTH && (rise || fall));
            wire          trig = (org == `COLC_ORG_INPUT && edge_hit) ||
                                 (org == `COLC_ORG_STROBE && strobe[g]);
            always @(posedge mclk) begin
                if (!rst_b) begin
                    st <= S_IDLE;
                    cnt <= {CW{1'b0}};
                    sub <= 4'h0;
                    held_level[g] <= 1'b0;
                    line_out[g] <= 1'b0;
                end else begin
                    if (org == `COLC_ORG_LEVEL && hold_latch[g] && strobe[g])
                        held_level[g] <= level_set[g];
                    case (st)
                        S_IDLE: begin
                            cnt <= {CW{1'b0}};
                            sub <= 4'h0;
                            if (trig && dir_out[g])
                                st <= S_DELAY;
                        end
                        // triggers while busy ignored until done
                        S_DELAY: begin
                            if (cnt >= delay_us) begin
                                st <= S_PULSE;
                                cnt <= {CW{1'b0}};
                                sub <= 4'h0;
                            end else begin
                                sub <= sub_wrap ? 4'h0 : sub + 4'h1;
                                if (sub_wrap)
                                    cnt <= cnt + 1'b1;
                            end
                        end
                        S_PULSE: begin
                            if (cnt >= width_us && width_us != {CW{1'b0}})
                                st <= S_IDLE;
                            else begin
                                sub <= sub_wrap ? 4'h0 : sub + 4'h1;
                                if (sub_wrap)
                                    cnt <= cnt + 1'b1;
                            end
                        end
                        default: st <= S_IDLE;
                    endcase
                    // 1 = circuit closed
                    case (org)
                        `COLC_ORG_LEVEL: line_out[g] <= hold_latch[g] ?
                                         held_level[g] : level_set[g];
                        `COLC_ORG_STROBE,
                        `COLC_ORG_INPUT: line_out[g] <= (st == S_PULSE) &&
                                         !(cnt >= width_us && width_us != {CW{1'b0}});
                        default: line_out[g] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

endmodule // colc_top

/* hw/colc_defines.vh */
// colc_defines.vh: register offsets, field positions, reset values and timing counts
// for the camera output line control block; assumes a 10 MHz mclk.
// How it works
// - With both-edges activation, a rising or a falling edge of the source starts a pulse.
// - After a trigger the line waits pulse_delay_us microseconds, only if the pin is output.
// - The pulse then stays asserted for pulse_width_us microseconds, or without end while it is zero.
// - With soft hold off, the line follows the static level setting directly.
// - The static level only matters when the origin is host-driven level.
// - With soft hold on latch, the pin changes only on a strobe, not on a level write.
// - Static level Active closes the output circuit, Inactive opens it.
// - A read returns every line level now, line one in bit zero, then two, three and four.
// - Any strobe value is accepted; bits zero and one, when set to one, each command their own line.
// - Strobe bit zero drives output line three and bit one drives output line four.
// - A strobe bit of one applies the held level or starts a pulse, per the line's origin.
// - Strobe pulses only on pulse-on-host-strobe lines, updates level only on latch lines.
// - Activation picks rising only, falling only, or either edge as the trigger.
// - A line with origin pulse-on-host-strobe pulses in answer to its strobe bit.
`ifndef COLC_DEFINES_VH
`define COLC_DEFINES_VH

`define COLC_CLK_MHZ        10
`define COLC_US_CYCLES      (`COLC_CLK_MHZ * 1)

// register byte addresses
`define COLC_A_ORIGIN       8'h00
`define COLC_A_ACTIV        8'h04
`define COLC_A_DELAY        8'h08
`define COLC_A_WIDTH        8'h0C
`define COLC_A_HOLD         8'h10
`define COLC_A_LEVEL        8'h14
`define COLC_A_STROBE       8'h18
`define COLC_A_STATUS       8'h1C
`define COLC_A_DIR          8'h20
`define COLC_A_SEL          8'h24

// per line origin select, 2 bits each
`define COLC_ORG_OFF        2'h0
`define COLC_ORG_LEVEL      2'h1
`define COLC_ORG_STROBE     2'h2
`define COLC_ORG_INPUT      2'h3

// activation encoding
`define COLC_ACT_RISE       2'h0
`define COLC_ACT_FALL       2'h1
`define COLC_ACT_BOTH       2'h2

`define COLC_DELAY_RST      24'h000000
`define COLC_WIDTH_RST      24'h000001
`define COLC_CNT_W          24

`define COLC_RESP_OKAY      2'h0
`define COLC_RESP_SLVERR    2'h2

`endif

/* bench/colc_chk.sv */
// colc_chk: bus handshake and output line assertions for colc_top
// sees only top ports, single mclk domain; bound below
`timescale 1ns/1ps
`include "colc_defines.vh"
module colc_chk #(parameter NOUT = 2) (
    input wire            mclk,
    input wire            rst_b,
    input wire [NOUT-1:0] line_out,
    input wire            s_axi_awvalid,
    input wire            s_axi_awready,
    input wire            s_axi_wvalid,
    input wire            s_axi_wready,
    input wire [1:0]      s_axi_bresp,
    input wire            s_axi_bvalid,
    input wire            s_axi_bready,
    input wire [7:0]      s_axi_araddr,
    input wire            s_axi_arvalid,
    input wire            s_axi_arready,
    input wire [31:0]     s_axi_rdata,
    input wire            s_axi_rvalid,
    input wire            s_axi_rready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    reg [7:0] ra;
    always @(posedge mclk) if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
    chk_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready high after capture");
    chk_ar_refused: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
        else $error("arready high after capture");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_strobe_reads: assert property (s_axi_rvalid && ra == `COLC_A_STROBE |->
        s_axi_rdata == 32'h0) else $error("strobe read not zero");
    chk_reset_idle: assert property (disable iff (1'b0) !rst_b |=> line_out == 0
        && !s_axi_bvalid && !s_axi_rvalid) else $error("not idle after reset");
endmodule // colc_chk
bind colc_top colc_chk #(.NOUT(NOUT)) i_chk (.mclk, .rst_b, .line_out, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* bench/colc_equip.sv */
// colc_equip: trigger source and lamp load on the camera lines
// registers bench trigger levels onto the inputs; counts cycles each output is closed
`timescale 1ns/1ps
module colc_equip (
    input wire        mclk,
    input wire [1:0]  src,
    input wire [1:0]  line_out,
    output reg [1:0]  line_in,
    output reg [15:0] hi3,
    output reg [15:0] hi4
);
    initial line_in = 2'h0;
    initial hi3 = 16'h0;
    initial hi4 = 16'h0;
    always @(posedge mclk) begin
        line_in <= src;
        hi3 <= hi3 + {15'h0, line_out[0]};
        hi4 <= hi4 + {15'h0, line_out[1]};
    end
endmodule // colc_equip

/* bench/tb_camera_output_line_control.sv */
// tb_camera_output_line_control: register driven tests of colc_top
// assumes colc_equip on the line pins and colc_chk bound to the design
`timescale 1ns/1ps
`include "colc_defines.vh"
module tb_camera_output_line_control;
    reg         mclk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
    reg  [31:0] wdata = 32'h0, rd_v;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [1:0]  src = 2'h0, rsp, lo;
    reg  [15:0] h0, h1;
    reg  [7:0]  rows [0:5];
    wire [1:0]  line_in, line_out, bresp, rresp;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [31:0] rdata;
    wire [15:0] hi3, hi4;
    integer     n_fail = 0, checked = 0, i, m, e;
    always #50 mclk = ~mclk;
    colc_top #(.NOUT(2), .NIN(2)) i_dut (.mclk(mclk), .rst_b(rst_b), .line_in(line_in),
        .line_out(line_out), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    colc_equip i_equip (.mclk(mclk), .src(src), .line_out(line_out), .line_in(line_in),
        .hi3(hi3), .hi4(hi4));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
            forever begin
                @(posedge mclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) break;
            end
            rsp = bresp;
            bready <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge mclk);
            araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
            forever begin
                @(posedge mclk);
                if (arready) arvalid <= 1'b0;
                if (rvalid) break;
            end
            rd_v = rdata; rsp = rresp; rready <= 1'b0;
        end
    endtask
    // closed time rounded to whole microseconds, absorbs tick phase
    function [31:0] us(input [15:0] d);
        us = (d + 16'h5) / 16'hA;
    endfunction
    task final_report;
        begin
            $display("checked=%0d n_fail=%0d", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail = n_fail + 1;
        final_report;
    end
    initial begin
        // row: origin, level, expected lines
        rows[0] = 8'h50; rows[1] = 8'h5F; rows[2] = 8'h55;
        rows[3] = 8'h5A; rows[4] = 8'h4E; rows[5] = 8'h1D;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        chk(line_out, 32'h0);
        rd(`COLC_A_DIR); chk(rd_v, 32'h3);
        rd(`COLC_A_WIDTH); chk(rd_v, 32'h1);
        for (i = 0; i < 6; i = i + 1) begin
            wr(`COLC_A_ORIGIN, {28'h0, rows[i][7:4]});
            wr(`COLC_A_LEVEL, {30'h0, rows[i][3:2]});
            chk(line_out, rows[i][1:0]);
            rd(`COLC_A_STATUS); chk(rd_v, {rows[i][1:0], 2'h0});
        end
        wr(`COLC_A_ORIGIN, 32'h5); wr(`COLC_A_HOLD, 32'h3);
        lo = line_out;
        wr(`COLC_A_LEVEL, 32'h3); chk(line_out, lo);
        wr(`COLC_A_STROBE, 32'h1); chk(line_out, {lo[1], 1'b1});
        wr(`COLC_A_STROBE, 32'h2); chk(line_out, 32'h3);
        wr(`COLC_A_LEVEL, 32'h0); chk(line_out, 32'h3);
        wr(`COLC_A_STROBE, 32'h3); chk(line_out, 32'h0);
        wr(`COLC_A_HOLD, 32'h0); wr(`COLC_A_ORIGIN, 32'h8); wr(`COLC_A_WIDTH, 32'h2);
        h0 = hi4; h1 = hi3;
        wr(`COLC_A_STROBE, 32'h3); repeat (60) @(posedge mclk);
        chk(us(hi4 - h0), 32'h2);
        chk(hi3 - h1, 32'h0);
        wr(`COLC_A_ORIGIN, 32'hF); wr(`COLC_A_WIDTH, 32'h1); wr(`COLC_A_DELAY, 32'h3);
        for (m = 0; m < 3; m = m + 1) begin
            wr(`COLC_A_ACTIV, m);
            for (e = 0; e < 2; e = e + 1) begin
                h0 = hi3;
                src <= (e == 0) ? 2'h3 : 2'h0;
                repeat (15) @(posedge mclk);
                chk(line_out[0], 32'h0);
                repeat (80) @(posedge mclk);
                chk(us(hi3 - h0), (e == 0) ? (m != 1) : (m != 0));
            end
        end
        wr(`COLC_A_DIR, 32'h0);
        h0 = hi3;
        src <= 2'h3;
        repeat (95) @(posedge mclk);
        chk(hi3 - h0, 32'h0);
        wr(`COLC_A_STATUS, 32'h1); chk(rsp, `COLC_RESP_SLVERR);
        rd(8'h30); chk(rsp, `COLC_RESP_SLVERR);
        rd(`COLC_A_STROBE); chk(rd_v, 32'h0); chk(rsp, `COLC_RESP_OKAY);
        wr(`COLC_A_ORIGIN, 32'h5); wr(`COLC_A_LEVEL, 32'h3); chk(line_out, 32'h3);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        chk(line_out, 32'h0);
        rd(`COLC_A_ORIGIN); chk(rd_v, 32'h0);
        rd(`COLC_A_DIR); chk(rd_v, 32'h3);
        final_report;
    end
endmodule // tb_camera_output_line_control
